/* File: include/cld_pkg.sv */
package cld_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_HOLD   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TEST   = 8'h0C;

  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] HOLD_RST   = 8'h04;
  localparam logic [1:0] TEST_RST   = 2'h0;

  // led_display_config field layout
  localparam int MODE_LSB      = 0;
  localparam int ALWAYS_ON_BIT = 3;
  localparam int COUNT_LSB     = 4;

  // display mode codes
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_SINGLE = 3'h1;
  localparam logic [2:0] SEL_FOUR   = 3'h2;
  localparam logic [2:0] SEL_EXT_2W = 3'h3;
  localparam logic [2:0] SEL_EXT_1W = 3'h4;

  // test register bits
  localparam int TEST_ON_BIT  = 0;
  localparam int TEST_OFF_BIT = 1;

  // status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_BUSY_BIT   = 1;
  localparam int STAT_LIT_LSB    = 8;
  localparam int STAT_PCT_LSB    = 16;

  // charge scale and display figures
  localparam logic [6:0] PCT_FULL       = 7'h64;
  localparam logic [6:0] SINGLE_CAP_PCT = 7'h5A;
  localparam logic [4:0] FOUR_LEDS      = 5'h04;
  localparam logic [4:0] CHAIN_ONE_REG  = 5'h08;
  localparam logic [4:0] EXT_MIN_LEDS   = 5'h02;
  localparam logic [1:0] REQ_HELD_SECS  = 2'h2;

  // request level: adc code of 2.5 v on the request pin
  localparam int         ADC_W          = 12;
  localparam logic [11:0] REQ_LEVEL_CODE = 12'h800;

  // timing
  localparam int CLK_NS        = 20;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_CYCLES    = SEC_NS / CLK_NS;
  localparam int SLOTS_PER_SEC = 100;
  localparam int SHIFT_HALF_NS = 1000;
  localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_NS - 1) / CLK_NS;

  // decoded display mode
  typedef enum logic [4:0] {
    MD_NONE   = 5'b00001,
    MD_SINGLE = 5'b00010,
    MD_FOUR   = 5'b00100,
    MD_EXT_2W = 5'b01000,
    MD_EXT_1W = 5'b10000
  } cld_mode_e;
endpackage

/* File: src/cld_lit_count.sv */
`timescale 1ns/1ps
module cld_lit_count (
  // charge and led count
  input  wire logic [6:0] charge_pct,
  input  wire logic [4:0] led_total,
  // number of leds to light
  output logic      [4:0] lit_count
);
  logic [10:0] prod;
  logic [10:0] quot;

  // equal steps over the leds, rounded up, zero at zero charge
  assign prod = 11'(charge_pct) * 11'(led_total);
  assign quot = 11'((prod + 11'(cld_pkg::PCT_FULL) - 11'd1) / 11'(cld_pkg::PCT_FULL));
  assign lit_count = quot[4:0];
endmodule

/* File: src/cld_shift_out.sv */
`timescale 1ns/1ps
module cld_shift_out (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // request
  input  wire logic       start,
  input  wire logic [4:0] lit_count,
  input  wire logic       long_chain,
  // serial pins and state
  output logic            shift_clk,
  output logic            shift_data,
  output logic            busy
);
  typedef enum logic [2:0] {
    SH_IDLE = 3'b001,
    SH_LOW  = 3'b010,
    SH_HIGH = 3'b100
  } cld_shift_e;

  localparam logic [7:0] HALF_LAST = 8'(cld_pkg::SHIFT_HALF_CYC - 1);

  cld_shift_e state_r, state_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [4:0] lit_r, lit_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       clk_r, clk_nxt;
  logic       dat_r, dat_nxt;

  // bits go out farthest led first; data settles a half period before the rise
  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    lit_nxt   = lit_r;
    cnt_nxt   = cnt_r + 8'd1;
    clk_nxt   = clk_r;
    dat_nxt   = dat_r;
    unique case (state_r)
      SH_IDLE: begin
        cnt_nxt = 8'd0;
        if (start) begin
          state_nxt = SH_LOW;
          lit_nxt   = lit_count;
          bit_nxt   = long_chain ? 5'd15 : 5'd7;
          dat_nxt   = (long_chain ? 5'd15 : 5'd7) < lit_count;
          clk_nxt   = 1'b0;
        end
      end
      SH_LOW: begin
        if (cnt_r == HALF_LAST) begin
          state_nxt = SH_HIGH;
          cnt_nxt   = 8'd0;
          clk_nxt   = 1'b1;
        end
      end
      SH_HIGH: begin
        if (cnt_r == HALF_LAST) begin
          cnt_nxt = 8'd0;
          clk_nxt = 1'b0;
          if (bit_r == 5'd0) begin
            state_nxt = SH_IDLE;
            dat_nxt   = 1'b0;
          end else begin
            state_nxt = SH_LOW;
            bit_nxt   = bit_r - 5'd1;
            dat_nxt   = (bit_r - 5'd1) < lit_r;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SH_IDLE;
      bit_r   <= 5'd0;
      lit_r   <= 5'd0;
      cnt_r   <= 8'd0;
      clk_r   <= 1'b0;
      dat_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      lit_r   <= lit_nxt;
      cnt_r   <= cnt_nxt;
      clk_r   <= clk_nxt;
      dat_r   <= dat_nxt;
    end
  end

  assign shift_clk  = clk_r;
  assign shift_data = dat_r;
  assign busy       = state_r != SH_IDLE;

  // data never moves on the cycle the clock rises
  property p_data_stable_at_rise;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(clk_r) |-> $stable(dat_r);
  endproperty
  a_data_stable_at_rise: assert property (p_data_stable_at_rise) else $error("shift data moved at clock rise");
endmodule

/* File: src/cld_display.sv */
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - mode field 2:0 selects none/single/four/external
// - always-on bit keeps display lit, not single
// - otherwise request held one to two seconds
// - hold interval: lit time or refresh period
// - count code 7:4 gives code plus one, code zero gives two
// - charge split evenly across external leds
// - adc level of 2.5 v means request
// - single led blinks 1 s, duty equals charge
// - single led duty capped at 90 percent
// - four leds form quarter-step bar graph
// - external chain shifted out, 8 or 16 bits
// - external leds blank after hold seconds
// - test bits force leds on or off
module cld_display #(
  parameter int unsigned SEC_CYCLES = cld_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // gauge inputs
  input  wire logic [6:0]  relative_charge_percent,
  input  wire logic [11:0] display_request_pin,
  // led and link pins
  output logic             first_led_or_shift_clock_pin,
  output logic             second_led_or_shift_data_pin,
  output logic             third_led_pin,
  output logic             fourth_led_pin,
  output logic             bias_supply_output,
  output logic             single_wire_link_sel
);
  localparam int unsigned SLOT_CYCLES = SEC_CYCLES / cld_pkg::SLOTS_PER_SEC;
  localparam logic [6:0]  SLOT_LAST   = 7'(cld_pkg::SLOTS_PER_SEC - 1);

  typedef enum logic [1:0] {
    DS_OFF = 2'b01,
    DS_ON  = 2'b10
  } cld_disp_e;

  // mode decode; illegal codes decode as no display, but the bias supply stays on
  function automatic cld_pkg::cld_mode_e mode_of(input logic [7:0] cfg);
    case (cfg[cld_pkg::MODE_LSB +: 3])
      cld_pkg::SEL_SINGLE: mode_of = cld_pkg::MD_SINGLE;
      cld_pkg::SEL_FOUR:   mode_of = cld_pkg::MD_FOUR;
      cld_pkg::SEL_EXT_2W: mode_of = cld_pkg::MD_EXT_2W;
      cld_pkg::SEL_EXT_1W: mode_of = cld_pkg::MD_EXT_1W;
      default:             mode_of = cld_pkg::MD_NONE;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == cld_pkg::ADDR_CONFIG) || (addr == cld_pkg::ADDR_HOLD) ||
                (addr == cld_pkg::ADDR_STATUS) || (addr == cld_pkg::ADDR_TEST);
  endfunction

  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  hold_r, hold_nxt;
  logic [1:0]  test_r, test_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] tb_r, tb_nxt;
  logic [6:0]  slot_r, slot_nxt;
  logic [1:0]  held_r, held_nxt;
  cld_disp_e   disp_r, disp_nxt;
  logic [7:0]  secs_r, secs_nxt;
  logic [6:0]  pct_r, pct_nxt;
  logic [4:0]  sent_r, sent_nxt;
  logic [3:0]  pins_r, pins_nxt;

  cld_pkg::cld_mode_e mode;
  logic       wr_en;
  logic       sec_tick;
  logic       req_level;
  logic       req_accept;
  logic       always_on;
  logic       force_on;
  logic       force_off;
  logic       disp_on;
  logic       is_ext;
  logic [7:0] hold_eff;
  logic [6:0] pct_in;
  logic [6:0] cap_pct;
  logic [4:0] led_total;
  logic [4:0] lit_now;
  logic [4:0] lit_eff;
  logic       sh_start;
  logic       sh_clk;
  logic       sh_data;
  logic       sh_busy;

  // decoded configuration
  assign mode      = mode_of(cfg_r);
  assign is_ext    = (mode == cld_pkg::MD_EXT_2W) || (mode == cld_pkg::MD_EXT_1W);
  assign always_on = cfg_r[cld_pkg::ALWAYS_ON_BIT] && (mode != cld_pkg::MD_SINGLE) &&
                     (mode != cld_pkg::MD_NONE);
  assign force_on  = test_r[cld_pkg::TEST_ON_BIT] && !test_r[cld_pkg::TEST_OFF_BIT];
  assign force_off = test_r[cld_pkg::TEST_OFF_BIT];
  assign disp_on   = disp_r == DS_ON;
  assign hold_eff  = (hold_r == 8'h00) ? 8'h01 : hold_r; // zero hold counts as a one second hold
  assign pct_in    = (relative_charge_percent > cld_pkg::PCT_FULL) ? cld_pkg::PCT_FULL
                                                                  : relative_charge_percent;
  assign cap_pct   = (pct_r > cld_pkg::SINGLE_CAP_PCT) ? cld_pkg::SINGLE_CAP_PCT : pct_r;

  // led total: reserved code zero falls back to the smallest chain
  always_comb begin
    if (mode == cld_pkg::MD_FOUR) begin
      led_total = cld_pkg::FOUR_LEDS;
    end else if (cfg_r[cld_pkg::COUNT_LSB +: 4] == 4'h0) begin
      led_total = cld_pkg::EXT_MIN_LEDS;
    end else begin
      led_total = 5'(cfg_r[cld_pkg::COUNT_LSB +: 4]) + 5'd1;
    end
  end

  cld_lit_count u_lit (
    .charge_pct (pct_r),
    .led_total  (led_total),
    .lit_count  (lit_now)
  );

  // pattern actually shown, test forcing overrides the charge level
  always_comb begin
    if (force_off) begin
      lit_eff = 5'd0;
    end else if (force_on) begin
      lit_eff = led_total;
    end else if (disp_on) begin
      lit_eff = lit_now;
    end else begin
      lit_eff = 5'd0;
    end
  end

  // apb: zero wait states, read data captured in the setup cycle
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata  = rd_r;

  always_comb begin
    cfg_nxt  = cfg_r;
    hold_nxt = hold_r;
    test_nxt = test_r;
    rd_nxt   = rd_r;
    if (wr_en && paddr == cld_pkg::ADDR_CONFIG) begin
      cfg_nxt = pwdata[7:0];
    end
    if (wr_en && paddr == cld_pkg::ADDR_HOLD) begin
      hold_nxt = pwdata[7:0];
    end
    if (wr_en && paddr == cld_pkg::ADDR_TEST) begin
      test_nxt = pwdata[1:0];
    end
    if (psel && !penable && !pwrite) begin
      rd_nxt = 32'h0000_0000;
      if (paddr == cld_pkg::ADDR_CONFIG) begin
        rd_nxt[7:0] = cfg_r;
      end else if (paddr == cld_pkg::ADDR_HOLD) begin
        rd_nxt[7:0] = hold_r;
      end else if (paddr == cld_pkg::ADDR_TEST) begin
        rd_nxt[1:0] = test_r;
      end else if (paddr == cld_pkg::ADDR_STATUS) begin
        rd_nxt[cld_pkg::STAT_ACTIVE_BIT]    = disp_on;
        rd_nxt[cld_pkg::STAT_BUSY_BIT]      = sh_busy;
        rd_nxt[cld_pkg::STAT_LIT_LSB +: 5]  = lit_eff;
        rd_nxt[cld_pkg::STAT_PCT_LSB +: 7]  = pct_r;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= cld_pkg::CONFIG_RST;
      hold_r <= cld_pkg::HOLD_RST;
      test_r <= cld_pkg::TEST_RST;
      rd_r   <= 32'h0000_0000;
    end else begin
      cfg_r  <= cfg_nxt;
      hold_r <= hold_nxt;
      test_r <= test_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // timebase: one hundred slots per second, slot is the blink step
  assign sec_tick = (tb_r == 32'(SLOT_CYCLES - 1)) && (slot_r == SLOT_LAST);

  always_comb begin
    tb_nxt   = tb_r + 32'd1;
    slot_nxt = slot_r;
    if (tb_r == 32'(SLOT_CYCLES - 1)) begin
      tb_nxt   = 32'h0000_0000;
      slot_nxt = (slot_r == SLOT_LAST) ? 7'd0 : slot_r + 7'd1;
    end
  end

  // request: level threshold, then two second ticks while held
  assign req_level  = display_request_pin >= cld_pkg::REQ_LEVEL_CODE;
  assign req_accept = req_level && sec_tick && (held_r == cld_pkg::REQ_HELD_SECS - 2'd1);

  always_comb begin
    held_nxt = held_r;
    if (!req_level) begin
      held_nxt = 2'd0;
    end else if (sec_tick && held_r != cld_pkg::REQ_HELD_SECS) begin
      held_nxt = held_r + 2'd1; // one press lights the display once
    end
  end

  // display state: on for the hold interval, or refreshed every interval
  always_comb begin
    disp_nxt = disp_r;
    secs_nxt = secs_r;
    pct_nxt  = pct_r;
    unique case (disp_r)
      DS_OFF: begin
        if (mode != cld_pkg::MD_NONE && (always_on || req_accept || force_on)) begin
          disp_nxt = DS_ON;
          secs_nxt = 8'd0;
          pct_nxt  = pct_in;
        end
      end
      DS_ON: begin
        if (mode == cld_pkg::MD_NONE) begin
          disp_nxt = DS_OFF;
        end else if (req_accept) begin
          secs_nxt = 8'd0;
          pct_nxt  = pct_in;
        end else if (sec_tick) begin
          secs_nxt = secs_r + 8'd1;
          if (secs_r + 8'd1 >= hold_eff) begin
            secs_nxt = 8'd0;
            pct_nxt  = pct_in;
            if (!always_on && !force_on) begin
              disp_nxt = DS_OFF;
            end
          end
        end
      end
    endcase
    // a shorter interval written mid-count must not leave the count past its end
    if (wr_en && paddr == cld_pkg::ADDR_HOLD) begin
      secs_nxt = 8'd0;
    end
  end

  // external chain: resend whenever the shown count differs from the last sent
  assign sh_start = is_ext && !sh_busy && (lit_eff != sent_r);

  always_comb begin
    sent_nxt = sent_r;
    if (!is_ext) begin
      sent_nxt = 5'd0;
    end else if (sh_start) begin
      sent_nxt = lit_eff;
    end
  end

  cld_shift_out u_shift (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .start      (sh_start),
    .lit_count  (lit_eff),
    .long_chain (led_total > cld_pkg::CHAIN_ONE_REG),
    .shift_clk  (sh_clk),
    .shift_data (sh_data),
    .busy       (sh_busy)
  );

  // pin mux per mode
  always_comb begin
    pins_nxt = 4'h0;
    unique case (mode)
      cld_pkg::MD_NONE: begin
        pins_nxt = 4'h0;
      end
      cld_pkg::MD_SINGLE: begin
        pins_nxt[0] = force_on || (!force_off && disp_on && slot_r < cap_pct);
      end
      cld_pkg::MD_FOUR: begin
        for (int i = 0; i < 4; i++) begin
          pins_nxt[i] = 5'(i) < lit_eff;
        end
      end
      cld_pkg::MD_EXT_2W, cld_pkg::MD_EXT_1W: begin
        pins_nxt[0] = sh_clk;
        pins_nxt[1] = sh_data;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_r   <= 32'h0000_0000;
      slot_r <= 7'd0;
      held_r <= 2'd0;
      disp_r <= DS_OFF;
      secs_r <= 8'd0;
      pct_r  <= 7'd0;
      sent_r <= 5'd0;
      pins_r <= 4'h0;
    end else begin
      tb_r   <= tb_nxt;
      slot_r <= slot_nxt;
      held_r <= held_nxt;
      disp_r <= disp_nxt;
      secs_r <= secs_nxt;
      pct_r  <= pct_nxt;
      sent_r <= sent_nxt;
      pins_r <= pins_nxt;
    end
  end

  // pins: bias follows the raw mode field code, link select the decoded mode
  assign first_led_or_shift_clock_pin = pins_r[0];
  assign second_led_or_shift_data_pin = pins_r[1];
  assign third_led_pin                = pins_r[2];
  assign fourth_led_pin               = pins_r[3];
  assign bias_supply_output           = cfg_r[cld_pkg::MODE_LSB +: 3] != cld_pkg::SEL_NONE;
  assign single_wire_link_sel         = mode == cld_pkg::MD_EXT_1W;

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_none_dark;
    (mode == cld_pkg::MD_NONE) |=> (pins_r == 4'h0);
  endproperty
  a_none_dark: assert property (p_none_dark) else $error("pins lit in no display mode");

  property p_always_on;
    (always_on && !force_off) |-> ##[0:1] disp_on;
  endproperty
  a_always_on: assert property (p_always_on) else $error("always on display not active");

  property p_no_request_stays_off;
    (!disp_on && !req_level && !always_on && !force_on) |=> !disp_on;
  endproperty
  a_no_request_stays_off: assert property (p_no_request_stays_off) else $error("display lit without request");

  property p_hold_bound;
    disp_on |-> (secs_r < hold_eff);
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("hold counter past interval");

  property p_single_duty;
    (mode == cld_pkg::MD_SINGLE && disp_on && !force_off && slot_r < cap_pct) |=> first_led_or_shift_clock_pin;
  endproperty
  a_single_duty: assert property (p_single_duty) else $error("single led off inside duty");

  property p_single_cap;
    (mode == cld_pkg::MD_SINGLE && !force_on && slot_r >= cld_pkg::SINGLE_CAP_PCT) |=> !first_led_or_shift_clock_pin;
  endproperty
  a_single_cap: assert property (p_single_cap) else $error("single led on past cap");

  property p_four_bar;
    (mode == cld_pkg::MD_FOUR && lit_eff == 5'd3) |=> ({fourth_led_pin, third_led_pin,
      second_led_or_shift_data_pin, first_led_or_shift_clock_pin} == 4'h7);
  endproperty
  a_four_bar: assert property (p_four_bar) else $error("bar graph wrong for three leds");

  property p_lit_rounding;
    disp_on && !force_on && !force_off |-> (lit_now == 5'd0) ? (pct_r == 7'd0) :
      ((11'(lit_now) * 11'd100 >= 11'(pct_r) * 11'(led_total)) &&
       (11'(lit_now - 5'd1) * 11'd100 < 11'(pct_r) * 11'(led_total)));
  endproperty
  a_lit_rounding: assert property (p_lit_rounding) else $error("lit count not rounded up");

  property p_force_off;
    (force_off && mode == cld_pkg::MD_FOUR) |=> (pins_r == 4'h0);
  endproperty
  a_force_off: assert property (p_force_off) else $error("forced off leds still lit");

  c_accept:    cover property (req_accept);
  c_ext_send:  cover property (sh_start && led_total > cld_pkg::CHAIN_ONE_REG);
  c_single_on: cover property (mode == cld_pkg::MD_SINGLE && disp_on && pct_r > cld_pkg::SINGLE_CAP_PCT);
endmodule

/* File: tb/cld_chain_model.sv */
`timescale 1ns/1ps
// two cascaded 8-bit serial-in shift registers feeding the led bar
module cld_chain_model #(
  parameter int unsigned LEN = 16
) (
  // serial pins from the display block
  input  wire logic           shift_clk,
  input  wire logic           shift_data,
  // parallel outputs, newest bit at position 0
  output logic      [LEN-1:0] q
);
  initial q = '0;

  // capture only on the rising clock, as the real part does
  always @(posedge shift_clk) begin
    q <= {q[LEN-2:0], shift_data};
  end
endmodule

/* File: tb/charge_level_led_display_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module charge_level_led_display_tb;
  localparam int unsigned SECS = 200; // short second keeps the run brief
  logic        core_clk = 0;
  logic        rst_n    = 0;
  logic        psel     = 0;
  logic        penable  = 0;
  logic        pwrite   = 0;
  logic [7:0]  paddr    = '0;
  logic [31:0] pwdata   = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  pct      = '0;
  logic [11:0] req      = '0;
  logic        p1, p2, p3, p4, bias, wire1;
  logic [15:0] chain_q;
  logic [31:0] rv;
  logic        re;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          on_cnt;

  always #10 core_clk = ~core_clk;

  cld_display #(.SEC_CYCLES(SECS)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .relative_charge_percent(pct), .display_request_pin(req),
    .first_led_or_shift_clock_pin(p1), .second_led_or_shift_data_pin(p2),
    .third_led_pin(p3), .fourth_led_pin(p4), .bias_supply_output(bias),
    .single_wire_link_sel(wire1));

  // partner sees the pins as clock and data in external modes
  cld_chain_model #(.LEN(16)) chain (.shift_clk(p1), .shift_data(p2), .q(chain_q));

  // hang guard, well above the sum of all waits below
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic t_regs();
    apb(0, cld_pkg::ADDR_CONFIG, 0); `CHK(rv, 32'h0000_0000)
    apb(0, cld_pkg::ADDR_HOLD, 0);   `CHK(rv, 32'h0000_0004)
    apb(0, cld_pkg::ADDR_TEST, 0);   `CHK(rv, 32'h0000_0000)
    apb(0, 8'h10, 0);                `CHK({re, rv}, 33'h1_0000_0000)
    apb(1, cld_pkg::ADDR_HOLD, 32'h0000_0001);
    `CHK(bias, 1'b0)
  endtask

  task automatic t_four();
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_0002);
    pct <= 7'd67; req <= 12'h7FF; wt(600);
    `CHK({p4, p3, p2, p1}, 4'b0000)
    req <= 12'h800; wt(150);
    `CHK({p4, p3, p2, p1}, 4'b0000)
    wt(350);
    `CHK({p4, p3, p2, p1}, 4'b0111)
    `CHK(bias, 1'b1)
    req <= 12'h000; wt(500);
    `CHK({p4, p3, p2, p1}, 4'b0000)
  endtask

  task automatic t_single(input logic [6:0] p, input int exp_on);
    // single mode stays lit for the hold interval: keep it past the counting window
    apb(1, cld_pkg::ADDR_HOLD, 32'h0000_0004);
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_0001);
    pct <= p; req <= 12'hFFF; wt(500);
    on_cnt = 0;
    repeat (SECS) begin
      @(posedge core_clk);
      if (p1 === 1'b1) on_cnt++;
    end
    `CHK(on_cnt, exp_on)
    req <= 12'h000; wt(500);
  endtask

  task automatic t_always_test();
    pct <= 7'd25;
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_000A); wt(10);
    `CHK({p4, p3, p2, p1}, 4'b0001)
    pct <= 7'd0;
    apb(1, cld_pkg::ADDR_HOLD, 32'h0000_0001); wt(SECS + 10);
    `CHK({p4, p3, p2, p1}, 4'b0000)
    apb(1, cld_pkg::ADDR_TEST, 32'h0000_0001); wt(5);
    `CHK({p4, p3, p2, p1}, 4'b1111)
    apb(1, cld_pkg::ADDR_TEST, 32'h0000_0003); wt(5);
    `CHK({p4, p3, p2, p1}, 4'b0000)
    apb(1, cld_pkg::ADDR_TEST, 32'h0000_0000);
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_0009); wt(300);
    `CHK(p1, 1'b0)
  endtask

  task automatic t_ext();
    pct <= 7'd35; // ten leds: 3.5 steps, rounded up to 4
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_009B); wt(2000);
    `CHK(chain_q, 16'h000F)
    `CHK(wire1, 1'b0)
    pct <= 7'd50; // four leds on one register: two lit
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_003C); wt(1100);
    `CHK(chain_q[7:0], 8'h03)
    `CHK(wire1, 1'b1)
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_0033); wt(1100); // always-on cleared: blank at hold expiry
    `CHK(chain_q[7:0], 8'h00)
    apb(1, cld_pkg::ADDR_CONFIG, 32'h0000_0000); wt(5);
    `CHK(bias, 1'b0)
  endtask

  initial begin
    wt(2);
    rst_n <= 1;
    t_regs();
    t_four();
    t_single(7'd95, 180);
    t_single(7'd10, 20);
    t_always_test();
    t_ext();
    stop_test();
  end
endmodule
